// >>> srwp_pkg.sv
`default_nettype none
package srwp_pkg;

    // ------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_ALL   = 8'h01;
    localparam logic [7:0] CMD_WRITE_SR2   = 8'h31;
    localparam logic [7:0] CMD_WRITE_SR3   = 8'h11;
    localparam logic [7:0] CMD_WRITE_ADDR  = 8'h71;
    localparam logic [7:0] CMD_READ_SR1    = 8'h05;
    localparam logic [7:0] CMD_READ_SR2    = 8'h35;
    localparam logic [7:0] CMD_READ_SR3    = 8'h15;
    localparam logic [7:0] CMD_WREN        = 8'h06;
    localparam logic [7:0] CMD_WRDI        = 8'h04;
    localparam logic [7:0] CMD_RST_ENABLE  = 8'h66;
    localparam logic [7:0] CMD_RST_DEVICE  = 8'h99;

    // ------------------------------------------------------------
    // Register selectors for the addressed write
    // ------------------------------------------------------------
    localparam logic [7:0] SEL_SR1         = 8'h01;
    localparam logic [7:0] SEL_SR2         = 8'h02;
    localparam logic [7:0] SEL_SR3         = 8'h03;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SR1_PROTECT_LOW_BIT     = 7;
    localparam int SR1_WEL_BIT             = 1;
    localparam int SR2_PROTECT_HIGH_BIT    = 0;
    localparam int SR2_QUAD_ENABLE_BIT     = 1;
    localparam int SR2_LOCK_BIT            = 2;
    localparam int SR3_PIN_ROLE_BIT        = 7;

    // ------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SR1_WR_MASK     = 8'hFC;
    localparam logic [7:0] SR2_WR_MASK     = 8'h47;
    localparam logic [7:0] SR3_WR_MASK     = 8'hE4;
    localparam logic [7:0] SR1_RESET       = 8'h00;
    localparam logic [7:0] SR2_RESET       = 8'h00;
    localparam logic [7:0] SR3_RESET       = 8'h20;

    localparam logic [2:0] BIT_CNT_LAST    = 3'h7;
    localparam logic [2:0] BYTE_CNT_MAX    = 3'h7;

    typedef enum logic [1:0] {
        SRWP_CMD,
        SRWP_COLLECT,
        SRWP_READ
    } srwp_state_t;

endpackage
`default_nettype wire

// >>> srwp_props.sv
`timescale 1ns/100ps
`default_nettype none
module srwp_props
(
    input  wire logic       CORE_CLK_I,
    input  wire logic       RESET_N_I,
    input  wire logic       WP_N_I,
    input  wire logic       HOLD_FUNC_EN_O,
    input  wire logic       RESET_FUNC_EN_O,
    input  wire logic       WP_FUNC_EN_O,
    input  wire logic       QUAD_MODE_O,
    input  wire logic       STATUS_WRITE_O,
    input  wire logic       WRITE_REJECT_O,
    input  wire logic [1:0] PROTECT_STATE_O
);
    // ----------------------------------------
    // Write decision
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    AST_ONE_RESULT: assert property (!(STATUS_WRITE_O && WRITE_REJECT_O))
        else $error("accept and reject together");
    AST_PULSE_SHORT: assert property (STATUS_WRITE_O |=> !STATUS_WRITE_O && !WRITE_REJECT_O)
        else $error("accept pulse too long");
    AST_LOCKDOWN_BLOCKS: assert property (STATUS_WRITE_O |-> !$past(PROTECT_STATE_O[1]))
        else $error("write accepted under lockdown");
    AST_PIN_PROTECT: assert property (STATUS_WRITE_O && $past(PROTECT_STATE_O) == 2'b01
        && !$past(QUAD_MODE_O) |-> $past(WP_N_I)) else $error("write accepted with pin low");
    AST_REJECT_KEEPS: assert property (WRITE_REJECT_O |-> ($stable(PROTECT_STATE_O)
        && $stable(QUAD_MODE_O) && $stable(RESET_FUNC_EN_O)) [*2]) else $error("reject changed bits");
    AST_OTP_FOREVER: assert property ($past(PROTECT_STATE_O) == 2'b11 |-> PROTECT_STATE_O[0])
        else $error("full protection left other than to 0,1");
    AST_NO_RELOAD_LOCKDOWN: assert property ($changed(PROTECT_STATE_O) && !STATUS_WRITE_O
        |-> PROTECT_STATE_O != 2'b10) else $error("reload gave lockdown");

    // ----------------------------------------
    // Pin roles
    // ----------------------------------------
    AST_QUAD_PINS: assert property (QUAD_MODE_O |-> !WP_FUNC_EN_O && !HOLD_FUNC_EN_O
        && !RESET_FUNC_EN_O) else $error("pin role active in quad mode");
    AST_PIN_ROLE: assert property (!QUAD_MODE_O |-> WP_FUNC_EN_O
        && (HOLD_FUNC_EN_O != RESET_FUNC_EN_O)) else $error("pin role not single");
endmodule

bind srwp_status_protect srwp_props u_props
(
    .CORE_CLK_I,
    .RESET_N_I,
    .WP_N_I,
    .HOLD_FUNC_EN_O,
    .RESET_FUNC_EN_O,
    .WP_FUNC_EN_O,
    .QUAD_MODE_O,
    .STATUS_WRITE_O,
    .WRITE_REJECT_O,
    .PROTECT_STATE_O
);
`default_nettype wire

// >>> srwp_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module srwp_spi_host
(
    output logic            sck_o,
    output logic            cs_n_o,
    output logic            si_o,
    input  wire logic       so_i
);
    logic [7:0] rd_byte;

    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        rd_byte = 8'h00;
    end

    // Mode 0 frame, MSB first, clock still outside
    task automatic frame(input logic [7:0] bytes [$]);
        int i;
        int b;
        cs_n_o = 1'b0;
        #80;
        for (i = 0; i < bytes.size(); i++)
        begin
            for (b = 7; b >= 0; b--)
            begin
                si_o = bytes[i][b];
                #40;
                sck_o = 1'b1;
                rd_byte = {rd_byte[6:0], so_i};
                #80;
                sck_o = 1'b0;
                #40;
            end
        end
        #80;
        cs_n_o = 1'b1;
        // No stale data once deselected
        si_o = ~si_o;
        #200;
    endtask
endmodule
`default_nettype wire

// >>> srwp_spi_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module srwp_spi_shifter
    import srwp_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    input  wire logic       si_i,
    input  wire logic [7:0] tx_byte_i,
    output logic      [7:0] rx_byte_o,
    output logic            rx_valid_o,
    output logic            cs_start_o,
    output logic            cs_end_o,
    output logic            cs_active_o,
    output logic            so_o,
    output logic            so_oe_n_o
);

    // ------------------------------------------------------------
    // Two-stage synchronisers
    // ------------------------------------------------------------
    logic [1:0] sck_meta_reg;
    logic [1:0] cs_meta_reg;
    logic [1:0] si_meta_reg;
    logic       sck_old_reg;
    logic       cs_old_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] rx_byte_reg;
    logic       rx_valid_reg;

    wire sck_s    = sck_meta_reg[1];
    wire cs_s     = cs_meta_reg[1];
    wire si_s     = si_meta_reg[1];
    wire sck_rise = sck_s & ~sck_old_reg & ~cs_s;
    wire sck_fall = ~sck_s & sck_old_reg & ~cs_s;
    wire cs_fall  = ~cs_s & cs_old_reg;
    wire cs_rise  = cs_s & ~cs_old_reg;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sck_meta_reg <= 2'h0;
            cs_meta_reg  <= 2'h3;
            si_meta_reg  <= 2'h0;
            sck_old_reg  <= 1'b0;
            cs_old_reg   <= 1'b1;
        end
        else
        begin
            sck_meta_reg <= {sck_meta_reg[0], sck_i};
            cs_meta_reg  <= {cs_meta_reg[0], cs_n_i};
            si_meta_reg  <= {si_meta_reg[0], si_i};
            sck_old_reg  <= sck_s;
            cs_old_reg   <= cs_s;
        end
    end

    // ------------------------------------------------------------
    // Mode 0 shifting: sample on rise, shift out on fall
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bit_cnt_reg  <= 3'h0;
            rx_sh_reg    <= 7'h00;
            tx_sh_reg    <= 8'h00;
            rx_byte_reg  <= 8'h00;
            rx_valid_reg <= 1'b0;
        end
        else
        begin
            rx_valid_reg <= 1'b0;
            if (cs_fall)
            begin
                bit_cnt_reg <= 3'h0;
                tx_sh_reg   <= 8'h00;
            end
            else if (sck_rise)
            begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                rx_sh_reg   <= {rx_sh_reg[5:0], si_s};
                if (bit_cnt_reg == BIT_CNT_LAST)
                begin
                    rx_byte_reg  <= {rx_sh_reg, si_s};
                    rx_valid_reg <= 1'b1;
                end
            end
            else if (sck_fall)
            begin
                if (bit_cnt_reg == 3'h0)
                    tx_sh_reg <= tx_byte_i;
                else
                    tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
        end
    end

    assign rx_byte_o   = rx_byte_reg;
    assign rx_valid_o  = rx_valid_reg;
    assign cs_start_o  = cs_fall;
    assign cs_end_o    = cs_rise;
    assign cs_active_o = ~cs_s;
    assign so_o        = tx_sh_reg[7];
    assign so_oe_n_o   = cs_s;

endmodule
`default_nettype wire

// >>> srwp_status_protect.sv
`timescale 1ns/100ps
`default_nettype none
module srwp_status_protect
    import srwp_pkg::*;
(
    input  wire logic       CORE_CLK_I,
    input  wire logic       RESET_N_I,
    input  wire logic       SPI_SCK_I,
    input  wire logic       SPI_CS_N_I,
    input  wire logic       SPI_SI_I,
    input  wire logic       WP_N_I,
    input  wire logic       HOLD_RESET_N_I,
    input  wire logic       NV_PROTECT_HIGH_I,
    input  wire logic       NV_PROTECT_LOW_I,
    input  wire logic       NV_LOCK_I,
    output logic            SPI_SO_O,
    output logic            SPI_SO_OE_N_O,
    output logic            HOLD_FUNC_EN_O,
    output logic            RESET_FUNC_EN_O,
    output logic            WP_FUNC_EN_O,
    output logic            QUAD_MODE_O,
    output logic            STATUS_WRITE_O,
    output logic            WRITE_REJECT_O,
    output logic      [1:0] PROTECT_STATE_O
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic write_allowed(input logic high, input logic low, input logic pin_high);
        write_allowed = (!high && !low) ||
                        (!high && low && pin_high);
    endfunction

    function automatic logic [1:0] reload(input logic high, input logic low, input logic lock);
        case ({high, low})
            2'b00:   reload = 2'b00;
            2'b01:   reload = 2'b01;
            2'b10:   reload = 2'b00;
            default: reload = lock ? 2'b11 : 2'b01;
        endcase
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] din, input logic [7:0] mask);
        merge = (old & ~mask) | (din & mask);
    endfunction

    // ------------------------------------------------------------
    // Serial link
    // ------------------------------------------------------------
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       cs_start;
    logic       cs_end;
    logic       cs_active;
    logic [7:0] tx_byte_reg;

    srwp_spi_shifter u_shifter (
        .clk_i       (CORE_CLK_I),
        .rst_n_i     (RESET_N_I),
        .sck_i       (SPI_SCK_I),
        .cs_n_i      (SPI_CS_N_I),
        .si_i        (SPI_SI_I),
        .tx_byte_i   (tx_byte_reg),
        .rx_byte_o   (rx_byte),
        .rx_valid_o  (rx_valid),
        .cs_start_o  (cs_start),
        .cs_end_o    (cs_end),
        .cs_active_o (cs_active),
        .so_o        (SPI_SO_O),
        .so_oe_n_o   (SPI_SO_OE_N_O)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] wp_meta_reg;
    logic [1:0] hold_meta_reg;

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            wp_meta_reg   <= 2'h3;
            hold_meta_reg <= 2'h3;
        end
        else
        begin
            wp_meta_reg   <= {wp_meta_reg[0], WP_N_I};
            hold_meta_reg <= {hold_meta_reg[0], HOLD_RESET_N_I};
        end
    end

    // ------------------------------------------------------------
    // Status state
    // ------------------------------------------------------------
    srwp_state_t state_reg;
    logic [7:0]  sr1_reg;
    logic [7:0]  sr2_reg;
    logic [7:0]  sr3_reg;
    logic        wel_reg;
    logic        nv_high_reg;
    logic        nv_low_reg;
    logic        nv_lock_reg;
    logic        boot_reg;
    logic        rst_armed_reg;
    logic [7:0]  cmd_reg;
    logic [2:0]  byte_cnt_reg;
    logic [7:0]  d0_reg;
    logic [7:0]  d1_reg;
    logic [7:0]  d2_reg;
    logic        wr_pulse_reg;
    logic        rej_pulse_reg;

    wire quad_en     = sr2_reg[SR2_QUAD_ENABLE_BIT];
    wire prot_high   = sr2_reg[SR2_PROTECT_HIGH_BIT];
    wire prot_low    = sr1_reg[SR1_PROTECT_LOW_BIT];
    wire pin_role    = sr3_reg[SR3_PIN_ROLE_BIT];
    wire wp_level    = quad_en ? 1'b1 : wp_meta_reg[1];
    wire hw_reset    = !quad_en && pin_role && !hold_meta_reg[1];
    wire allowed     = wel_reg && write_allowed(prot_high, prot_low, wp_level);
    wire is_write    = (cmd_reg == CMD_WRITE_ALL) || (cmd_reg == CMD_WRITE_SR2) ||
                       (cmd_reg == CMD_WRITE_SR3) || (cmd_reg == CMD_WRITE_ADDR);
    wire has_data    = (cmd_reg == CMD_WRITE_ADDR) ? (byte_cnt_reg >= 3'h3) : (byte_cnt_reg >= 3'h2);
    wire wr_event    = cs_end && is_write && has_data;
    wire wr_commit   = wr_event && allowed;
    wire sw_reset    = cs_end && (cmd_reg == CMD_RST_DEVICE) && (byte_cnt_reg == 3'h1) && rst_armed_reg;
    wire any_reset   = boot_reg || hw_reset || sw_reset;
    wire [1:0] nv_pr = boot_reg ? reload(NV_PROTECT_HIGH_I, NV_PROTECT_LOW_I, NV_LOCK_I)
                                : reload(nv_high_reg, nv_low_reg, nv_lock_reg);

    // Write data routed to each register
    wire sel1 = (cmd_reg == CMD_WRITE_ALL) || ((cmd_reg == CMD_WRITE_ADDR) && (d0_reg == SEL_SR1));
    wire sel2 = ((cmd_reg == CMD_WRITE_ALL) && (byte_cnt_reg >= 3'h3)) || (cmd_reg == CMD_WRITE_SR2) ||
                ((cmd_reg == CMD_WRITE_ADDR) && (d0_reg == SEL_SR2));
    wire sel3 = ((cmd_reg == CMD_WRITE_ALL) && (byte_cnt_reg >= 3'h4)) || (cmd_reg == CMD_WRITE_SR3) ||
                ((cmd_reg == CMD_WRITE_ADDR) && (d0_reg == SEL_SR3));
    wire [7:0] dat1 = (cmd_reg == CMD_WRITE_ADDR) ? d1_reg : d0_reg;
    wire [7:0] dat2 = (cmd_reg == CMD_WRITE_ALL) ? d1_reg : dat1;
    wire [7:0] dat3 = (cmd_reg == CMD_WRITE_ALL) ? d2_reg : dat1;
    wire [7:0] sr1_new = sel1 ? merge(sr1_reg, dat1, SR1_WR_MASK) : sr1_reg;
    wire [7:0] sr2_new = sel2 ? merge(sr2_reg, dat2, SR2_WR_MASK) : sr2_reg;
    wire [7:0] sr3_new = sel3 ? merge(sr3_reg, dat3, SR3_WR_MASK) : sr3_reg;

    wire [7:0] sr1_view = {sr1_reg[7:2], wel_reg, 1'b0};
    wire [7:0] rd_value = (cmd_reg == CMD_READ_SR2) ? sr2_reg :
                          (cmd_reg == CMD_READ_SR3) ? sr3_reg : sr1_view;

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            state_reg    <= SRWP_CMD;
            cmd_reg      <= 8'h00;
            byte_cnt_reg <= 3'h0;
            d0_reg       <= 8'h00;
            d1_reg       <= 8'h00;
            d2_reg       <= 8'h00;
            tx_byte_reg  <= 8'h00;
        end
        else if (cs_start)
        begin
            state_reg    <= SRWP_CMD;
            byte_cnt_reg <= 3'h0;
            cmd_reg      <= 8'h00;
            tx_byte_reg  <= 8'h00;
        end
        else if (rx_valid && cs_active)
        begin
            if (byte_cnt_reg != BYTE_CNT_MAX)
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
            case (state_reg)
                SRWP_CMD:
                begin
                    cmd_reg <= rx_byte;
                    if ((rx_byte == CMD_READ_SR1) || (rx_byte == CMD_READ_SR2) || (rx_byte == CMD_READ_SR3))
                        state_reg <= SRWP_READ;
                    else
                        state_reg <= SRWP_COLLECT;
                end
                SRWP_COLLECT:
                begin
                    if (byte_cnt_reg == 3'h1)
                        d0_reg <= rx_byte;
                    if (byte_cnt_reg == 3'h2)
                        d1_reg <= rx_byte;
                    if (byte_cnt_reg == 3'h3)
                        d2_reg <= rx_byte;
                end
                SRWP_READ:
                begin
                    state_reg <= SRWP_READ;
                end
                default:
                begin
                    state_reg <= SRWP_CMD;
                end
            endcase
        end
        else if (state_reg == SRWP_READ)
        begin
            tx_byte_reg <= rd_value;
        end
    end

    // ------------------------------------------------------------
    // Status registers and protection
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            sr1_reg       <= SR1_RESET;
            sr2_reg       <= SR2_RESET;
            sr3_reg       <= SR3_RESET;
            wel_reg       <= 1'b0;
            nv_high_reg   <= 1'b0;
            nv_low_reg    <= 1'b0;
            nv_lock_reg   <= 1'b0;
            boot_reg      <= 1'b1;
            rst_armed_reg <= 1'b0;
            wr_pulse_reg  <= 1'b0;
            rej_pulse_reg <= 1'b0;
        end
        else
        begin
            boot_reg      <= 1'b0;
            wr_pulse_reg  <= wr_commit;
            rej_pulse_reg <= wr_event && !allowed;
            if (boot_reg)
            begin
                nv_high_reg <= NV_PROTECT_HIGH_I;
                nv_low_reg  <= NV_PROTECT_LOW_I;
                nv_lock_reg <= NV_LOCK_I;
                sr2_reg[SR2_LOCK_BIT] <= NV_LOCK_I;
            end
            if (any_reset)
            begin
                sr2_reg[SR2_PROTECT_HIGH_BIT] <= nv_pr[1];
                sr1_reg[SR1_PROTECT_LOW_BIT]  <= nv_pr[0];
                wel_reg       <= 1'b0;
                rst_armed_reg <= 1'b0;
            end
            else if (wr_commit)
            begin
                sr1_reg     <= sr1_new;
                sr2_reg     <= sr2_new;
                sr3_reg     <= sr3_new;
                nv_low_reg  <= sr1_new[SR1_PROTECT_LOW_BIT];
                nv_high_reg <= sr2_new[SR2_PROTECT_HIGH_BIT];
                nv_lock_reg <= sr2_new[SR2_LOCK_BIT];
                wel_reg     <= 1'b0;
            end
            else if (cs_end && byte_cnt_reg == 3'h1)
            begin
                if (cmd_reg == CMD_WREN)
                    wel_reg <= 1'b1;
                if (cmd_reg == CMD_WRDI)
                    wel_reg <= 1'b0;
                rst_armed_reg <= (cmd_reg == CMD_RST_ENABLE);
            end
            else if (cs_end && byte_cnt_reg != 3'h0)
            begin
                rst_armed_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign HOLD_FUNC_EN_O  = !quad_en && !pin_role;
    assign RESET_FUNC_EN_O = !quad_en && pin_role;
    assign WP_FUNC_EN_O    = !quad_en;
    assign QUAD_MODE_O     = quad_en;
    assign STATUS_WRITE_O  = wr_pulse_reg;
    assign WRITE_REJECT_O  = rej_pulse_reg;
    assign PROTECT_STATE_O = {prot_high, prot_low};

endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import srwp_pkg::*;
    logic       core_clk;
    logic       reset_n;
    logic       wp_n;
    logic       hold_reset_n;
    logic [2:0] nv;
    logic       sck;
    logic       cs_n;
    logic       si;
    logic       so;
    logic       so_oe_n;
    logic       hold_en;
    logic       reset_en;
    logic       wp_en;
    logic       quad;
    logic       status_write;
    logic       write_reject;
    logic [1:0] prot;
    logic       exp_q [$];
    logic [1:0] reload_map [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h3};
    int         n_errors;
    int         tests_run;
    int         seed;
    int         i;

    always #5 core_clk = ~core_clk;

    srwp_spi_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));

    srwp_status_protect dut
    (
        .CORE_CLK_I(core_clk), .RESET_N_I(reset_n), .SPI_SCK_I(sck), .SPI_CS_N_I(cs_n),
        .SPI_SI_I(si), .WP_N_I(wp_n), .HOLD_RESET_N_I(hold_reset_n), .NV_PROTECT_HIGH_I(nv[2]),
        .NV_PROTECT_LOW_I(nv[1]), .NV_LOCK_I(nv[0]), .SPI_SO_O(so), .SPI_SO_OE_N_O(so_oe_n),
        .HOLD_FUNC_EN_O(hold_en), .RESET_FUNC_EN_O(reset_en), .WP_FUNC_EN_O(wp_en),
        .QUAD_MODE_O(quad), .STATUS_WRITE_O(status_write), .WRITE_REJECT_O(write_reject),
        .PROTECT_STATE_O(prot)
    );

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic report_and_stop;
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pulse(input logic got_acc);
        logic e;
        tests_run++;
        e = (exp_q.size() != 0) ? exp_q.pop_front() : 1'bx;
        if (e !== got_acc)
        begin
            n_errors++;
            $display("Error %0t: write outcome %b, expected %b", $time, got_acc, e);
        end
    endtask

    always @(negedge core_clk)
        if (status_write === 1'b1 || write_reject === 1'b1)
            chk_pulse(status_write);

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task automatic drive_pins(input logic wp, input logic hr);
        @(posedge core_clk);
        #1;
        wp_n = wp;
        hold_reset_n = hr;
    endtask

    task automatic por(input logic [2:0] v);
        @(posedge core_clk);
        #1;
        reset_n = 1'b0;
        nv = v;
        repeat (4) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic wr(input logic wren, input logic acc, input logic [7:0] b [$]);
        int k;
        if (wren)
            host.frame({CMD_WREN});
        exp_q.push_back(acc);
        host.frame(b);
        for (k = 0; k < 40 && exp_q.size() != 0; k++)
            @(posedge core_clk);
        if (exp_q.size() != 0)
        begin
            n_errors++;
            $display("Error %0t: no write outcome", $time);
            report_and_stop();
        end
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        host.frame({cmd, 8'h00});
        chk_val(host.rd_byte, exp);
    endtask

    task automatic soft_reset;
        host.frame({CMD_RST_ENABLE});
        host.frame({CMD_RST_DEVICE});
    endtask

    initial
    begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        wp_n = 1'b1;
        hold_reset_n = 1'b1;
        nv = 3'h0;
        n_errors = 0;
        tests_run = 0;
        seed = 32'hd897;
        for (i = 0; i < 8; i++)
        begin
            por(i[2:0]);
            chk_val({6'h00, prot}, {6'h00, reload_map[i]});
        end
        por(3'h0);
        rd(CMD_READ_SR3, SR3_RESET);
        chk_val({3'h0, so_oe_n, quad, wp_en, hold_en, reset_en}, 8'h16);
        host.frame({CMD_WREN});
        rd(CMD_READ_SR1, 8'h02);
        host.frame({CMD_WRDI});
        wr(1'b0, 1'b0, {CMD_WRITE_SR2, 8'h02});
        wr(1'b0, 1'b0, {CMD_WRITE_SR3, 8'h80});
        wr(1'b1, 1'b1, {CMD_WRITE_SR3, 8'hA0});
        rd(CMD_READ_SR3, 8'hA0);
        chk_val({4'h0, quad, wp_en, hold_en, reset_en}, 8'h05);
        wr(1'b1, 1'b1, {CMD_WRITE_ADDR, SEL_SR1, 8'h80});
        chk_val({6'h00, prot}, 8'h01);
        drive_pins(1'b0, 1'b1);
        wr(1'b1, 1'b0, {CMD_WRITE_SR2, 8'($random(seed))});
        chk_val({6'h00, prot}, 8'h01);
        drive_pins(1'b1, 1'b1);
        wr(1'b1, 1'b1, {CMD_WRITE_SR3, 8'hA0});
        wr(1'b1, 1'b1, {CMD_WRITE_SR2, 8'h01});
        chk_val({6'h00, prot}, 8'h03);
        rd(CMD_READ_SR2, 8'h01);
        wr(1'b1, 1'b0, {CMD_WRITE_SR3, 8'($random(seed))});
        soft_reset();
        chk_val({6'h00, prot}, 8'h01);
        wr(1'b1, 1'b1, {CMD_WRITE_ALL, 8'h00, 8'h01});
        chk_val({6'h00, prot}, 8'h02);
        wr(1'b1, 1'b0, {CMD_WRITE_SR2, 8'h00});
        drive_pins(1'b1, 1'b0);
        repeat (4) @(posedge core_clk);
        drive_pins(1'b1, 1'b1);
        repeat (4) @(posedge core_clk);
        chk_val({6'h00, prot}, 8'h00);
        wr(1'b1, 1'b1, {CMD_WRITE_SR2, 8'h02});
        chk_val({4'h0, quad, wp_en, hold_en, reset_en}, 8'h08);
        wr(1'b1, 1'b1, {CMD_WRITE_ADDR, SEL_SR1, 8'h80});
        drive_pins(1'b0, 1'b1);
        wr(1'b1, 1'b1, {CMD_WRITE_SR3, 8'h20});
        drive_pins(1'b1, 1'b1);
        por(3'h7);
        wr(1'b1, 1'b0, {CMD_WRITE_SR2, 8'($random(seed))});
        soft_reset();
        chk_val({6'h00, prot}, 8'h03);
        report_and_stop();
    end
endmodule
`default_nettype wire
